//--- core/fci_defs.svh
// Constants for the flash command interface host controller
// Summary of operation
// - Identifier pin at high voltage: bit 0 low gives maker code, high device.
// - Erased cells read one; program all to zero before any bulk erase.
// - Command writes need the programming supply high, chip select, low strobe.
// - 0040h arms program; next strobe gives address and data, starts it.
// - Host waits at least 10 us before program-verify command 00C0h.
// - Host verifies every programmed word and reprograms it on mismatch.
// - Two 0020h writes start bulk erase; a single one never erases.
// - Host waits at least 10 ms before erase-verify command 00A0h.
// - After each erase the host erase-verifies from the current word to the last.
// - FFFFh means erased; any other word forces another erase.
// - 00FFh written twice cancels armed program or erase, back to read.
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH

// ==========================================================================
// Clock and bus timing
`define FCI_CLK_MHZ      200
`define FCI_T_ELWL_NS    20
`define FCI_T_WLWH_NS    60
`define FCI_T_WHWL_NS    20
`define FCI_T_ACC_NS     170
`define FCI_T_GHQZ_NS    35
`define FCI_T_WHGL_US    6
`define FCI_T_VPEL_US    1
`define FCI_T_PROG_US    10
`define FCI_T_ERASE_MS   10
// Least times round up to whole cycles
`define FCI_CYC_ELWL  ((`FCI_T_ELWL_NS * `FCI_CLK_MHZ + 999) / 1000)
`define FCI_CYC_WLWH  ((`FCI_T_WLWH_NS * `FCI_CLK_MHZ + 999) / 1000)
`define FCI_CYC_WHWL  ((`FCI_T_WHWL_NS * `FCI_CLK_MHZ + 999) / 1000)
`define FCI_CYC_ACC   ((`FCI_T_ACC_NS * `FCI_CLK_MHZ + 999) / 1000)
`define FCI_CYC_GHQZ  ((`FCI_T_GHQZ_NS * `FCI_CLK_MHZ + 999) / 1000)
`define FCI_CYC_WHGL  (`FCI_T_WHGL_US * `FCI_CLK_MHZ)
`define FCI_CYC_VPEL  (`FCI_T_VPEL_US * `FCI_CLK_MHZ)
`define FCI_CYC_PROG  (`FCI_T_PROG_US * `FCI_CLK_MHZ)
`define FCI_CYC_ERASE (`FCI_T_ERASE_MS * 1000 * `FCI_CLK_MHZ)

// ==========================================================================
// Command codes and data values
`define FCI_CMD_READ     16'h0000
`define FCI_CMD_ID       16'h0090
`define FCI_CMD_ERASE    16'h0020
`define FCI_CMD_EVERIFY  16'h00A0
`define FCI_CMD_PROGRAM  16'h0040
`define FCI_CMD_PVERIFY  16'h00C0
`define FCI_CMD_RESET    16'h00FF
`define FCI_ERASED_WORD  16'hFFFF
`define FCI_ZERO_WORD    16'h0000
`define FCI_LAST_ADDR    16'hFFFF
`define FCI_ID_BYTE_MASK 16'h00FF
`define FCI_MAX_PROG_TRIES  25
`define FCI_MAX_ERASE_TRIES 1000

`endif

//--- core/fci_pkg.sv
// Types for the flash command interface host controller
package fci_pkg;

  // ========================================================================
  // User operations
  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_ERASE   = 3'h2,
    OP_ID_CMD  = 3'h3,
    OP_ID_PIN  = 3'h4,
    OP_RESET   = 3'h5
  } fci_op_t;

  // ========================================================================
  // Sequencer states, Gray in listed order from S_IDLE to S_DONE
  typedef enum logic [4:0] {
    S_IDLE   = 5'b00000,
    S_VPP    = 5'b00001,
    S_P_SET  = 5'b00011,
    S_P_DATA = 5'b00010,
    S_P_WAIT = 5'b00110,
    S_P_VFY  = 5'b00111,
    S_P_READ = 5'b00101,
    S_E_SET  = 5'b00100,
    S_E_GO   = 5'b01100,
    S_E_WAIT = 5'b01101,
    S_E_VFY  = 5'b01111,
    S_E_READ = 5'b01110,
    S_EXIT   = 5'b01010,
    S_DONE   = 5'b01011,
    S_ID_CMD = 5'b01001,
    S_RD     = 5'b01000,
    S_RST1   = 5'b11000,
    S_RST2   = 5'b11001
  } fci_state_t;

  // ========================================================================
  // Bus cycle phases
  typedef enum logic [2:0] {
    B_IDLE   = 3'b000,
    B_SETUP  = 3'b001,
    B_STROBE = 3'b011,
    B_HOLD   = 3'b010,
    B_REC    = 3'b110,
    B_ACC    = 3'b111,
    B_DIS    = 3'b101
  } fci_bus_t;

endpackage : fci_pkg

//--- core/fci_bus_cycle.sv
// One timed write or read cycle on the flash parallel pins
`timescale 1ns/1ps
`include "fci_defs.svh"

module fci_bus_cycle #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic                   done,
  output logic      [DATA_W-1:0] rdata,
  output logic                   e_n,
  output logic                   g_n,
  output logic                   w_n,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe
);

  fci_pkg::fci_bus_t bstate, next_bstate;
  logic [10:0]       cnt, next_cnt;
  logic [10:0]       rec, next_rec;
  logic              next_done, next_e_n, next_g_n, next_w_n, next_dq_oe;
  logic [DATA_W-1:0] next_rdata, next_dq_o;
  logic [ADDR_W-1:0] next_addr_o;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_bstate = bstate;
    next_cnt    = (cnt != 11'h000) ? cnt - 11'h001 : cnt;
    next_rec    = (rec != 11'h000) ? rec - 11'h001 : rec;
    next_done   = 1'b0;
    next_e_n    = e_n;
    next_g_n    = g_n;
    next_w_n    = w_n;
    next_dq_oe  = dq_oe;
    next_rdata  = rdata;
    next_dq_o   = dq_o;
    next_addr_o = addr_o;
    case (bstate)
      fci_pkg::B_IDLE: begin
        if (start) begin
          next_addr_o = addr;
          next_dq_o   = wdata;
          if (wr) begin
            // chip select low ahead of strobe
            next_e_n    = 1'b0;
            next_dq_oe  = 1'b1;
            next_cnt    = 11'(`FCI_CYC_ELWL - 1);
            next_bstate = fci_pkg::B_SETUP;
          end else begin
            next_bstate = fci_pkg::B_REC;
          end
        end
      end
      fci_pkg::B_SETUP: begin
        if (cnt == 11'h000) begin
          next_w_n    = 1'b0;
          next_cnt    = 11'(`FCI_CYC_WLWH - 1);
          next_bstate = fci_pkg::B_STROBE;
        end
      end
      fci_pkg::B_STROBE: begin
        if (cnt == 11'h000) begin
          next_w_n    = 1'b1;
          next_cnt    = 11'(`FCI_CYC_WHWL - 1);
          next_bstate = fci_pkg::B_HOLD;
        end
      end
      fci_pkg::B_HOLD: begin
        if (cnt == 11'h000) begin
          next_e_n    = 1'b1;
          next_dq_oe  = 1'b0;
          next_rec    = 11'(`FCI_CYC_WHGL);
          next_done   = 1'b1;
          next_bstate = fci_pkg::B_IDLE;
        end
      end
      fci_pkg::B_REC: begin
        // Reads wait out the write recovery time
        if (rec == 11'h000) begin
          // both selects low only while our drivers are off
          next_e_n    = 1'b0;
          next_g_n    = 1'b0;
          next_cnt    = 11'(`FCI_CYC_ACC - 1);
          next_bstate = fci_pkg::B_ACC;
        end
      end
      fci_pkg::B_ACC: begin
        if (cnt == 11'h000) begin
          next_rdata  = dq_in;
          next_e_n    = 1'b1;
          next_g_n    = 1'b1;
          next_cnt    = 11'(`FCI_CYC_GHQZ - 1);
          next_bstate = fci_pkg::B_DIS;
        end
      end
      fci_pkg::B_DIS: begin
        // let the device float before we drive again
        if (cnt == 11'h000) begin
          next_done   = 1'b1;
          next_bstate = fci_pkg::B_IDLE;
        end
      end
      default: next_bstate = fci_pkg::B_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bstate <= fci_pkg::B_IDLE;
      cnt    <= 11'h000;
      rec    <= 11'h000;
      done   <= 1'b0;
      e_n    <= 1'b1;
      g_n    <= 1'b1;
      w_n    <= 1'b1;
      dq_oe  <= 1'b0;
      rdata  <= '0;
      dq_o   <= '0;
      addr_o <= '0;
    end else begin
      bstate <= next_bstate;
      cnt    <= next_cnt;
      rec    <= next_rec;
      done   <= next_done;
      e_n    <= next_e_n;
      g_n    <= next_g_n;
      w_n    <= next_w_n;
      dq_oe  <= next_dq_oe;
      rdata  <= next_rdata;
      dq_o   <= next_dq_o;
      addr_o <= next_addr_o;
    end
  end

endmodule : fci_bus_cycle

//--- core/fci_host.sv
// Host sequencer that reads, programs, erases and identifies the flash
`timescale 1ns/1ps
`include "fci_defs.svh"

module fci_host #(
  parameter int unsigned ERASE_WAIT_CYC = `FCI_CYC_ERASE,
  parameter int unsigned PROG_TRIES     = `FCI_MAX_PROG_TRIES,
  parameter int unsigned ERASE_TRIES    = `FCI_MAX_ERASE_TRIES
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CMD_VALID,
  input  wire logic [2:0]  CMD_OP,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [15:0] CMD_DATA,
  output logic             CMD_READY,
  output logic             RESP_VALID,
  output logic      [15:0] RESP_DATA,
  output logic             RESP_OK,
  output logic             FL_E_N,
  output logic             FL_G_N,
  output logic             FL_W_N,
  output logic      [15:0] FL_ADDR,
  output logic      [15:0] FL_DQ_OUT,
  output logic             FL_DQ_OE,
  input  wire logic [15:0] FL_DQ_IN,
  output logic             FL_VPP_HIGH,
  output logic             FL_HV_ID
);

  fci_pkg::fci_state_t state, next_state;
  fci_pkg::fci_op_t    op, next_op;
  logic [31:0] wait_cnt, next_wait;
  logic [15:0] addr, next_addr;
  logic [15:0] data, next_data;
  logic [15:0] tries, next_tries;
  logic        issued, next_issued;
  logic        zfill, next_zfill;
  logic        fail, next_fail;
  logic        next_ready, next_resp_valid, next_resp_ok;
  logic [15:0] next_resp_data;
  logic        next_vpp, next_hv;
  logic        bus_state, step, bc_start, bc_wr, bc_done;
  logic [15:0] bc_addr, bc_wdata, bc_rdata;

  // ==========================================================================
  // Pin cycle engine
  fci_bus_cycle #(
    .ADDR_W (16),
    .DATA_W (16)
  ) u_bus (
    .clock  (CLOCK),
    .rst_n  (RST_N),
    .start  (bc_start),
    .wr     (bc_wr),
    .addr   (bc_addr),
    .wdata  (bc_wdata),
    .dq_in  (FL_DQ_IN),
    .done   (bc_done),
    .rdata  (bc_rdata),
    .e_n    (FL_E_N),
    .g_n    (FL_G_N),
    .w_n    (FL_W_N),
    .addr_o (FL_ADDR),
    .dq_o   (FL_DQ_OUT),
    .dq_oe  (FL_DQ_OE)
  );

  // ==========================================================================
  // Sequencer next-state logic
  always_comb begin
    next_state      = state;
    next_op         = op;
    next_wait       = (wait_cnt != 32'h0000_0000) ? wait_cnt - 32'h0000_0001
                                                  : wait_cnt;
    next_addr       = addr;
    next_data       = data;
    next_tries      = tries;
    next_zfill      = zfill;
    next_fail       = fail;
    next_ready      = CMD_READY;
    next_resp_valid = 1'b0;
    next_resp_data  = RESP_DATA;
    next_resp_ok    = RESP_OK;
    next_vpp        = FL_VPP_HIGH;
    next_hv         = FL_HV_ID;
    bus_state = !(state inside {fci_pkg::S_IDLE, fci_pkg::S_VPP,
                                fci_pkg::S_P_WAIT, fci_pkg::S_E_WAIT,
                                fci_pkg::S_DONE});
    bc_start    = bus_state && !issued;
    step        = issued && bc_done;
    next_issued = step ? 1'b0 : (issued || bc_start);
    bc_wr       = 1'b1;
    bc_addr     = addr;
    bc_wdata    = `FCI_CMD_READ;
    case (state)
      fci_pkg::S_IDLE: begin
        if (CMD_VALID) begin
          next_ready = 1'b0;
          next_op    = fci_pkg::fci_op_t'(CMD_OP);
          next_addr  = CMD_ADDR;
          next_data  = CMD_DATA;
          next_tries = 16'h0000;
          next_fail  = 1'b0;
          next_zfill = 1'b0;
          case (fci_pkg::fci_op_t'(CMD_OP))
            fci_pkg::OP_READ: next_state = fci_pkg::S_RD;
            fci_pkg::OP_ID_PIN: begin
              // high voltage pin, other address bits low
              next_hv    = 1'b1;
              next_addr  = {15'h0000, CMD_ADDR[0]};
              next_state = fci_pkg::S_RD;
            end
            default: begin
              // erase starts by zeroing the whole array
              next_zfill = (CMD_OP == fci_pkg::OP_ERASE);
              if (CMD_OP == fci_pkg::OP_ERASE) begin
                next_addr = 16'h0000;
              end
              // raise the programming supply before writes
              next_vpp   = 1'b1;
              next_wait  = 32'(`FCI_CYC_VPEL);
              next_state = fci_pkg::S_VPP;
            end
          endcase
        end
      end
      fci_pkg::S_VPP: begin
        if (wait_cnt == 32'h0000_0000) begin
          case (op)
            fci_pkg::OP_PROGRAM: next_state = fci_pkg::S_P_SET;
            fci_pkg::OP_ERASE:   next_state = fci_pkg::S_P_SET;
            fci_pkg::OP_ID_CMD:  next_state = fci_pkg::S_ID_CMD;
            fci_pkg::OP_RESET:   next_state = fci_pkg::S_RST1;
            default:             next_state = fci_pkg::S_DONE;
          endcase
        end
      end
      fci_pkg::S_P_SET: begin
        bc_wdata = `FCI_CMD_PROGRAM;
        if (step) next_state = fci_pkg::S_P_DATA;
      end
      fci_pkg::S_P_DATA: begin
        bc_wdata = zfill ? `FCI_ZERO_WORD : data;
        if (step) begin
          next_wait  = 32'(`FCI_CYC_PROG);
          next_state = fci_pkg::S_P_WAIT;
        end
      end
      fci_pkg::S_P_WAIT: begin
        if (wait_cnt == 32'h0000_0000) next_state = fci_pkg::S_P_VFY;
      end
      fci_pkg::S_P_VFY: begin
        bc_wdata = `FCI_CMD_PVERIFY;
        if (step) next_state = fci_pkg::S_P_READ;
      end
      fci_pkg::S_P_READ: begin
        bc_wr = 1'b0;
        if (step) begin
          if (bc_rdata != (zfill ? `FCI_ZERO_WORD : data)) begin
            next_tries = tries + 16'h0001;
            if (32'(tries) + 32'h0000_0001 >= PROG_TRIES) begin
              next_fail  = 1'b1;
              next_state = fci_pkg::S_EXIT;
            end else begin
              next_state = fci_pkg::S_P_SET;
            end
          end else if (!zfill) begin
            next_state = fci_pkg::S_EXIT;
          end else if (addr == `FCI_LAST_ADDR) begin
            next_zfill = 1'b0;
            next_tries = 16'h0000;
            next_addr  = 16'h0000;
            next_state = fci_pkg::S_E_SET;
          end else begin
            next_tries = 16'h0000;
            next_addr  = addr + 16'h0001;
            next_state = fci_pkg::S_P_SET;
          end
        end
      end
      fci_pkg::S_E_SET: begin
        bc_wdata = `FCI_CMD_ERASE;
        if (step) next_state = fci_pkg::S_E_GO;
      end
      fci_pkg::S_E_GO: begin
        bc_wdata = `FCI_CMD_ERASE;
        if (step) begin
          next_wait  = ERASE_WAIT_CYC;
          next_state = fci_pkg::S_E_WAIT;
        end
      end
      fci_pkg::S_E_WAIT: begin
        if (wait_cnt == 32'h0000_0000) next_state = fci_pkg::S_E_VFY;
      end
      fci_pkg::S_E_VFY: begin
        // verify address rides the command write
        bc_wdata = `FCI_CMD_EVERIFY;
        if (step) next_state = fci_pkg::S_E_READ;
      end
      fci_pkg::S_E_READ: begin
        bc_wr = 1'b0;
        if (step) begin
          // anything but all ones needs another erase
          if (bc_rdata != `FCI_ERASED_WORD) begin
            next_tries = tries + 16'h0001;
            if (32'(tries) + 32'h0000_0001 >= ERASE_TRIES) begin
              next_fail  = 1'b1;
              next_state = fci_pkg::S_EXIT;
            end else begin
              next_state = fci_pkg::S_E_SET;
            end
          // walk every word of the array
          end else if (addr == `FCI_LAST_ADDR) begin
            next_state = fci_pkg::S_EXIT;
          end else begin
            next_addr  = addr + 16'h0001;
            next_state = fci_pkg::S_E_VFY;
          end
        end
      end
      fci_pkg::S_ID_CMD: begin
        // identifier mode, then read word 0 or 1
        bc_wdata = `FCI_CMD_ID;
        if (step) begin
          next_addr  = {15'h0000, addr[0]};
          next_state = fci_pkg::S_RD;
        end
      end
      fci_pkg::S_RD: begin
        bc_wr = 1'b0;
        if (step) begin
          next_resp_data = bc_rdata;
          // identifier codes carry a zero upper byte
          if (op == fci_pkg::OP_ID_CMD || op == fci_pkg::OP_ID_PIN) begin
            next_resp_data = bc_rdata & `FCI_ID_BYTE_MASK;
          end
          next_state = (op == fci_pkg::OP_ID_CMD) ? fci_pkg::S_EXIT
                                                  : fci_pkg::S_DONE;
        end
      end
      fci_pkg::S_RST1: begin
        // two reset writes back to back
        bc_wdata = `FCI_CMD_RESET;
        if (step) next_state = fci_pkg::S_RST2;
      end
      fci_pkg::S_RST2: begin
        bc_wdata = `FCI_CMD_RESET;
        if (step) next_state = fci_pkg::S_DONE;
      end
      fci_pkg::S_EXIT: begin
        // leave the device in array read
        bc_wdata = `FCI_CMD_READ;
        if (step) next_state = fci_pkg::S_DONE;
      end
      fci_pkg::S_DONE: begin
        next_vpp        = 1'b0;
        next_hv         = 1'b0;
        next_resp_valid = 1'b1;
        next_resp_ok    = !fail;
        next_ready      = 1'b1;
        next_state      = fci_pkg::S_IDLE;
      end
      default: next_state = fci_pkg::S_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state       <= fci_pkg::S_IDLE;
      op          <= fci_pkg::OP_READ;
      wait_cnt    <= 32'h0000_0000;
      addr        <= 16'h0000;
      data        <= 16'h0000;
      tries       <= 16'h0000;
      issued      <= 1'b0;
      zfill       <= 1'b0;
      fail        <= 1'b0;
      CMD_READY   <= 1'b1;
      RESP_VALID  <= 1'b0;
      RESP_DATA   <= 16'h0000;
      RESP_OK     <= 1'b0;
      FL_VPP_HIGH <= 1'b0;
      FL_HV_ID    <= 1'b0;
    end else begin
      state       <= next_state;
      op          <= next_op;
      wait_cnt    <= next_wait;
      addr        <= next_addr;
      data        <= next_data;
      tries       <= next_tries;
      issued      <= next_issued;
      zfill       <= next_zfill;
      fail        <= next_fail;
      CMD_READY   <= next_ready;
      RESP_VALID  <= next_resp_valid;
      RESP_DATA   <= next_resp_data;
      RESP_OK     <= next_resp_ok;
      FL_VPP_HIGH <= next_vpp;
      FL_HV_ID    <= next_hv;
    end
  end

endmodule : fci_host

//--- test/fci_host_asserts.sv
// Port checker for the flash host sequencer
`timescale 1ns/1ps
module fci_host_asserts #(
  parameter int unsigned ERASE_WAIT_CYC = 2000000
) (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        FL_E_N,
  input wire logic        FL_G_N,
  input wire logic        FL_W_N,
  input wire logic [15:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_OUT,
  input wire logic        FL_DQ_OE,
  input wire logic        FL_VPP_HIGH,
  input wire logic        FL_HV_ID,
  input wire logic        RESP_VALID,
  input wire logic        RESP_OK
);
  localparam int PROG_MIN = 2000;
  localparam int STROBE_MIN = 12;
  // ======
  // Gap since last strobe rise and kind of that write
  logic [31:0] gap, next_gap;
  logic [15:0] prev, next_prev;
  logic [4:0]  wl, next_wl;
  logic        run_p, next_run_p, run_e, next_run_e;
  always_comb begin
    next_gap = (gap == 32'hFFFF_FFFF) ? gap : gap + 32'h0000_0001;
    next_prev = prev;
    next_run_p = run_p;
    next_run_e = run_e;
    next_wl = FL_W_N ? 5'h00 : wl + 5'h01;
    if (FL_W_N && wl != 5'h00) begin
      next_gap = 32'h0000_0000;
      next_prev = FL_DQ_OUT;
      // Program data equal to 0040h must not look like a second arm
      next_run_p = (prev == 16'h0040) && !run_p;
      next_run_e = (prev == 16'h0020) && (FL_DQ_OUT == 16'h0020);
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      gap <= 32'h0000_0000;
      prev <= 16'h0000;
      wl <= 5'h00;
      run_p <= 1'b0;
      run_e <= 1'b0;
    end else begin
      gap <= next_gap;
      prev <= next_prev;
      wl <= next_wl;
      run_p <= next_run_p;
      run_e <= next_run_e;
    end
  end
  // ======
  // Pin relations
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  AST_READ_GATE: assert property (!FL_G_N |-> !FL_E_N && !FL_DQ_OE)
    else $error("gate low without select or with host drive");
  AST_DESELECT: assert property (FL_E_N |-> FL_G_N && FL_W_N && !FL_DQ_OE)
    else $error("bus active while deselected");
  AST_WRITE_VPP: assert property (!FL_W_N |-> FL_VPP_HIGH && !FL_E_N)
    else $error("strobe without supply high or select");
  AST_WRITE_DRIVE: assert property (!FL_W_N |-> FL_DQ_OE && FL_G_N)
    else $error("strobe without data drive");
  AST_HOLD_STROBE: assert property (!FL_W_N ##1 !FL_W_N |->
    $stable(FL_ADDR) && $stable(FL_DQ_OUT))
    else $error("address or data moved under strobe");
  AST_STROBE_WIDTH: assert property (FL_W_N && wl != 5'h00 |->
    wl >= STROBE_MIN)
    else $error("strobe too short");
  AST_PROG_WAIT: assert property ($fell(FL_W_N) && run_p |->
    gap + 32'h0000_0001 >= PROG_MIN)
    else $error("verify written too soon after program");
  AST_ERASE_WAIT: assert property ($fell(FL_W_N) && run_e |->
    gap + 32'h0000_0001 >= ERASE_WAIT_CYC)
    else $error("verify written too soon after erase");
  AST_ID_PIN: assert property (FL_HV_ID |-> !FL_VPP_HIGH && FL_W_N)
    else $error("identifier pin raised with supply or strobe");
  C_FAIL: cover property (RESP_VALID && !RESP_OK);
  C_HV: cover property ($rose(FL_HV_ID));
  C_PROG: cover property ($fell(FL_W_N) && run_p);
endmodule : fci_host_asserts

bind fci_host fci_host_asserts #(.ERASE_WAIT_CYC(ERASE_WAIT_CYC)) i_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .FL_E_N(FL_E_N), .FL_G_N(FL_G_N),
  .FL_W_N(FL_W_N), .FL_ADDR(FL_ADDR), .FL_DQ_OUT(FL_DQ_OUT),
  .FL_DQ_OE(FL_DQ_OE), .FL_VPP_HIGH(FL_VPP_HIGH), .FL_HV_ID(FL_HV_ID),
  .RESP_VALID(RESP_VALID), .RESP_OK(RESP_OK));

//--- test/fci_flash_model.sv
// Behavioural flash device on the parallel pins
`timescale 1ns/1ps
module fci_flash_model #(
  // Arbitrary identifier values
  parameter logic [15:0] MAKER_CODE  = 16'h005A,
  parameter logic [15:0] DEVICE_CODE = 16'h00C3,
  // Core supply above the write lockout threshold
  parameter logic        CORE_OK     = 1'b1
) (
  input  wire logic        e_n,
  input  wire logic        g_n,
  input  wire logic        w_n,
  input  wire logic        vpp,
  input  wire logic        hv_id,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] dq_host,
  input  wire logic        dq_host_oe,
  output logic      [15:0] dq_bus
);
  typedef enum logic [2:0] {
    M_RD, M_ID, M_PS, M_PV, M_ES, M_EV, M_RS
  } fci_mode_t;
  logic [15:0] mem [0:65535];
  logic [15:0] wa, pa, va, rd;
  logic [15:0] last = 16'h0000;
  fci_mode_t   mode = M_RD;
  int          i;
  initial for (i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
  task decode(input logic [15:0] c);
    case (c)
      16'h0000: mode = M_RD;
      16'h0090: mode = M_ID;
      16'h0040: mode = M_PS;
      16'h00C0: mode = M_PV;
      16'h0020: mode = M_ES;
      16'h00A0: begin
        mode = M_EV;
        va = wa;
      end
      16'h00FF: mode = M_RS;
      default: ;
    endcase
  endtask : decode
  always @(negedge w_n) if (!e_n) wa = addr;
  always @(posedge w_n) if (!e_n && vpp && CORE_OK) begin
    if ((mode == M_PS || mode == M_ES) && dq_host == 16'h00FF) mode = M_RS;
    else if (mode == M_RS && dq_host == 16'h00FF) mode = M_RD;
    else if (mode == M_PS) begin
      pa = wa;
      mem[wa] = mem[wa] & dq_host;
      mode = M_RD;
    end else if (mode == M_ES && dq_host == 16'h0020) begin
      for (i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
      mode = M_RD;
    end else decode(dq_host);
  end
  // identifier codes have a zero upper byte
  assign rd = (hv_id || mode == M_ID) ? (addr[0] ? DEVICE_CODE : MAKER_CODE)
            : (mode == M_PV) ? mem[pa] : (mode == M_EV) ? mem[va] : mem[addr];
  always @(rd or e_n or g_n) if (!e_n && !g_n) last = rd;
  // released bus shows no stale value
  assign dq_bus = dq_host_oe ? dq_host : (!e_n && !g_n) ? rd : ~last;
endmodule : fci_flash_model

//--- test/testbench.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] MAKER = 16'h005A;
  localparam logic [15:0] DEVICE = 16'h00C3;
  typedef struct {
    logic [2:0] op; logic [15:0] a; logic [15:0] d;
    logic [15:0] exp; logic ok; logic cd;
  } fci_row_t;
  logic        clock, rst_n = 0, cmd_valid = 0, cmd_ready, resp_valid, resp_ok;
  logic [2:0]  cmd_op = 3'h0;
  logic [15:0] cmd_addr = 16'h0000, cmd_data = 16'h0000, resp_data;
  logic        fl_e_n, fl_g_n, fl_w_n, fl_dq_oe, fl_vpp_high, fl_hv_id;
  logic [15:0] fl_addr, fl_dq_out, fl_dq_in, got;
  int          n_errors = 0, check_count = 0, i;
  fci_row_t    rows [10] = '{
    '{3'h0, 16'h0010, 16'h0000, 16'hFFFF, 1'b1, 1'b1},
    '{3'h3, 16'h0000, 16'h0000, MAKER, 1'b1, 1'b1},
    '{3'h3, 16'h0001, 16'h0000, DEVICE, 1'b1, 1'b1},
    '{3'h4, 16'h0000, 16'h0000, MAKER, 1'b1, 1'b1},
    '{3'h4, 16'h0001, 16'h0000, DEVICE, 1'b1, 1'b1},
    '{3'h1, 16'h0010, 16'hA5C3, 16'h0000, 1'b1, 1'b0},
    '{3'h0, 16'h0010, 16'h0000, 16'hA5C3, 1'b1, 1'b1},
    '{3'h5, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0},
    '{3'h1, 16'h0010, 16'hFFFF, 16'h0000, 1'b0, 1'b0},
    '{3'h6, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0}};
  fci_host #(.ERASE_WAIT_CYC(50), .PROG_TRIES(3), .ERASE_TRIES(3)) i_dut (
    .CLOCK(clock), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
    .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .RESP_OK(resp_ok),
    .FL_E_N(fl_e_n), .FL_G_N(fl_g_n), .FL_W_N(fl_w_n), .FL_ADDR(fl_addr),
    .FL_DQ_OUT(fl_dq_out), .FL_DQ_OE(fl_dq_oe), .FL_DQ_IN(fl_dq_in),
    .FL_VPP_HIGH(fl_vpp_high), .FL_HV_ID(fl_hv_id));
  fci_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) i_model (
    .e_n(fl_e_n), .g_n(fl_g_n), .w_n(fl_w_n), .vpp(fl_vpp_high),
    .hv_id(fl_hv_id), .addr(fl_addr), .dq_host(fl_dq_out),
    .dq_host_oe(fl_dq_oe), .dq_bus(fl_dq_in));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task print_verdict;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Request raised once ready and held for one cycle, then wait for the end pulse
  task run_op(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d);
    int k;
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    k = 0;
    while (resp_valid !== 1'b1 && k < 60000) begin
      @(posedge clock);
      #1;
      k++;
    end
    got = resp_data;
    if (k >= 60000) begin
      n_errors++;
      $display("[ERR] t=%0t response timeout", $time);
    end
  endtask : run_op
  initial begin
    #500000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    for (i = 0; i < 10; i++) begin
      run_op(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].cd) chk(got, rows[i].exp);
      chk({15'h0000, resp_ok}, {15'h0000, rows[i].ok});
      $display("row %0d done", i);
    end
    // Erase cut short by reset while zero-filling
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = 3'h2;
    @(negedge clock);
    cmd_valid = 1'b0;
    repeat (1500) @(negedge clock);
    chk(i_model.mem[0], 16'h0000);
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    chk({13'h0000, fl_e_n, fl_vpp_high, cmd_ready}, 16'h0005);
    rst_n = 1'b1;
    run_op(3'h5, 16'h0000, 16'h0000);
    run_op(3'h0, 16'h0000, 16'h0000);
    chk(got, 16'h0000);
    run_op(3'h0, 16'h0010, 16'h0000);
    chk(got, 16'hA5C3);
    $display("reset and abort test done");
    print_verdict();
  end
endmodule : testbench
